// ### inc/avp_pkg.sv
/*
 * Analog value preprocessor shared definitions: raw value codes,
 * smoothing factor selection codes, cycle timing and the carrier
 * structs used at the top module ports and by the testbench.
 * Assumes a single 100 MHz system clock.
 */
`default_nettype none

package avp_pkg;

    // ========================================================================
    // raw value codes
    // ========================================================================
    localparam logic signed [15:0] AVP_CODE_OVERFLOW  = 16'sh7FFF;
    localparam logic signed [15:0] AVP_CODE_UNDERFLOW = 16'sh8000;
    localparam logic signed [15:0] AVP_NOMINAL_TOP    = 16'sh6C00;
    localparam logic signed [15:0] AVP_OVERRANGE_TOP  = 16'sh7EFF;
    localparam logic signed [15:0] AVP_UNDERRANGE_BOT = 16'sh8100;
    localparam logic signed [15:0] AVP_LIMIT_OFF      = 16'sh0000;
    localparam logic signed [15:0] AVP_ZERO           = 16'sh0000;

    // ========================================================================
    // smoothing factor selection (k = 1, 4, 32, 64)
    // ========================================================================
    typedef enum logic [1:0] {
        AVP_K1  = 2'h0,
        AVP_K4  = 2'h1,
        AVP_K32 = 2'h2,
        AVP_K64 = 2'h3
    } avp_kfac_t;

    // shift amount for each k (k is a power of two)
    localparam logic [2:0] AVP_SHIFT_K1  = 3'h0;
    localparam logic [2:0] AVP_SHIFT_K4  = 3'h2;
    localparam logic [2:0] AVP_SHIFT_K32 = 3'h5;
    localparam logic [2:0] AVP_SHIFT_K64 = 3'h6;

    // ========================================================================
    // timing
    // ========================================================================
    localparam int unsigned AVP_CLK_HZ        = 100_000_000;
    localparam int unsigned AVP_CYCLE_MS      = 500;
    localparam int unsigned AVP_CYCLE_CLKS    = AVP_CLK_HZ / 1000 * AVP_CYCLE_MS;
    localparam int unsigned AVP_SUPP_DEF_CYC  = 4;

    // ========================================================================
    // reset values
    // ========================================================================
    localparam logic       AVP_RST_FLAG = 1'b0;

    // ========================================================================
    // carrier structs
    // ========================================================================
    // per data point configuration
    typedef struct packed {
        logic              unipolar_en;
        logic              src_input_module;
        logic              src_software;
        logic              mean_active;
        logic              trig_cfg;
        logic              status_proto;
        avp_kfac_t         kfac;
        logic [15:0]       supp_cycles;
        logic signed [15:0] lim_high;
        logic signed [15:0] lim_low;
    } avp_cfg_t;

    // transmit output
    typedef struct packed {
        logic              valid;
        logic signed [15:0] value;
        logic              range_violation_flag;
    } avp_tx_t;

    // ========================================================================
    // shared function: overflow/underflow code test
    // ========================================================================
    function automatic logic avp_is_fault(input logic signed [15:0] v);
        avp_is_fault = (v == AVP_CODE_OVERFLOW) || (v == AVP_CODE_UNDERFLOW);
    endfunction : avp_is_fault

endpackage : avp_pkg

`default_nettype wire

// ### rtl/avp_preproc.sv
/*
 * Analog value preprocessor for one data point: unipolar clamp, fault
 * suppression, exponential smoothing and high/low limit comparison.
 * Assumes raw values are synchronous to i_clk_sys and held stable; the
 * configuration is static ports; the output is a transfer strobe with value.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - unipolar option clamps negative values to zero
// - input module wire-break code passes clamp unchanged
// - software input values below zero become zero
// - clamp ignored while mean generation active
// - suppression needs trigger, off under mean generation
// - overflow/underflow codes withheld during suppression time
// - after expiry send code only if persisting
// - early return sends current in-range value
// - smoothing needs trigger, off under mean generation
// - smoothed equals (x plus (k-1)y) over k
// - factor k selectable as 1, 4, 32, 64
// - limit check only for memory-sourced points
// - above high limit sets flag, below clears
// - below low limit sets flag, above clears
// - flag updated at transfer, status protocols only
// - zero limit disables that comparison
// - limits are signed 16-bit raw values
// - stale limit value still evaluated when nonzero
// - steps run every 500 ms cycle
module avp_preproc #(
    parameter int unsigned CYCLE_CLKS = avp_pkg::AVP_CYCLE_CLKS
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_nrst,
    input  wire avp_pkg::avp_cfg_t  i_cfg,
    input  wire logic signed [15:0] i_raw,
    output avp_pkg::avp_tx_t        o_tx,
    output logic                    o_cycle_tick
);
    import avp_pkg::*;

    // clock and reset for the checks below
    default clocking avp_cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    // one-hot sequencer phases
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EVAL  = 3'b010,
        ST_SEND  = 3'b100
    } avp_phase_t;

    typedef struct packed {
        avp_phase_t         phase;
        logic [31:0]        tick_cnt;
        logic signed [15:0] clamped;
        logic               fault;
        logic               tx_valid;
        logic signed [15:0] tx_value;
        logic               flag;
    } avp_state_t;

    avp_state_t state;
    avp_state_t next_state;

    logic               cycle_tick;
    logic               supp_en;
    logic               smooth_off;
    logic               hold;
    logic signed [15:0] smoothed;
    logic signed [15:0] clamp_val;
    logic               lim_allowed;
    logic               lim_step;

    // ========================================================================
    // unipolar clamp
    // ========================================================================
    function automatic logic signed [15:0] avp_clamp(
        input logic signed [15:0] v,
        input logic               en,
        input logic               from_module
    );
        if (en && v < AVP_ZERO) begin
            if (from_module && v == AVP_CODE_UNDERFLOW) begin
                avp_clamp = v;
            end else begin
                avp_clamp = AVP_ZERO;
            end
        end else begin
            avp_clamp = v;
        end
    endfunction : avp_clamp

    // clamp is off under mean generation
    assign clamp_val = avp_clamp(i_raw, i_cfg.unipolar_en && !i_cfg.mean_active,
                                 i_cfg.src_input_module && !i_cfg.src_software);

    // ========================================================================
    // 500 ms cycle tick
    // ========================================================================
    assign cycle_tick = (state.tick_cnt == 32'(CYCLE_CLKS - 1));

    // gating of the triggered options
    assign supp_en    = i_cfg.trig_cfg && !i_cfg.mean_active;
    assign smooth_off = !i_cfg.trig_cfg || i_cfg.mean_active;
    assign lim_allowed = i_cfg.trig_cfg && !i_cfg.src_input_module;

    // ========================================================================
    // helpers
    // ========================================================================
    // suppression cycle counter
    avp_supp_timer u_timer (
        .i_clk_sys  (i_clk_sys),
        .i_nrst     (i_nrst),
        .i_step     (state.phase == ST_EVAL),
        .i_enable   (supp_en),
        .i_fault    (state.fault),
        .i_duration (i_cfg.supp_cycles),
        .o_hold     (hold)
    );

    // smoother, stepped on in-range cycles
    avp_smooth u_smooth (
        .i_clk_sys  (i_clk_sys),
        .i_nrst     (i_nrst),
        .i_step     (state.phase == ST_EVAL && !state.fault),
        .i_bypass   (smooth_off),
        .i_kfac     (i_cfg.kfac),
        .i_sample   (state.clamped),
        .o_smoothed (smoothed)
    );

    // ========================================================================
    // limit comparison with hysteresis-free set/clear
    // ========================================================================
    function automatic logic avp_limit_flag(
        input logic               prev,
        input logic signed [15:0] v,
        input logic signed [15:0] hi,
        input logic signed [15:0] lo
    );
        logic hi_on;
        logic lo_on;
        logic r;
        hi_on = (hi != AVP_LIMIT_OFF);
        lo_on = (lo != AVP_LIMIT_OFF);
        r = prev;
        if ((hi_on && v > hi) || (lo_on && v < lo)) begin
            r = 1'b1;
        end else if ((!hi_on || v < hi) && (!lo_on || v > lo)) begin
            r = 1'b0;
        end
        if (!hi_on && !lo_on) begin
            r = 1'b0;
        end
        avp_limit_flag = r;
    endfunction : avp_limit_flag

    // ========================================================================
    // sequencer
    // ========================================================================
    always_comb begin
        logic signed [15:0] outv;
        outv = AVP_ZERO;
        next_state = state;
        // valid is a one-cycle pulse
        next_state.tx_valid = 1'b0;
        // free-running cycle counter
        next_state.tick_cnt = cycle_tick ? 32'h00000000
                                         : state.tick_cnt + 32'h00000001;
        unique case (state.phase)
            ST_IDLE: begin
                if (cycle_tick) begin
                    // capture the clamped sample for this cycle
                    next_state.clamped = clamp_val;
                    next_state.fault   = avp_is_fault(clamp_val);
                    next_state.phase   = ST_EVAL;
                end
            end

            ST_EVAL: begin
                next_state.phase = ST_SEND;
            end

            ST_SEND: begin
                if (state.fault) begin
                    // code sent only once suppression elapsed and still present
                    next_state.tx_valid = !hold;
                    outv = state.clamped;
                end else begin
                    // in-range value goes out at once, smoothed if enabled
                    next_state.tx_valid = 1'b1;
                    outv = smoothed;
                end
                next_state.tx_value = outv;
                if (!hold && i_cfg.status_proto && lim_allowed) begin
                    // flag tracks the transferred value
                    next_state.flag = avp_limit_flag(state.flag, outv,
                                                     i_cfg.lim_high, i_cfg.lim_low);
                end
                next_state.phase = ST_IDLE;
            end

            default: begin
                next_state.phase = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            state       <= '0;
            state.phase <= ST_IDLE;
            state.flag  <= AVP_RST_FLAG;
        end else begin
            state <= next_state;
        end
    end

    // ========================================================================
    // outputs
    // ========================================================================
    // registered transfer outputs
    assign o_tx.valid                = state.tx_valid;
    assign o_tx.value                = state.tx_value;
    assign o_tx.range_violation_flag = state.flag;
    assign o_cycle_tick              = cycle_tick;

    // ========================================================================
    // assertions
    // ========================================================================
    sequence s_send_fault_held;
        state.phase == ST_SEND && state.fault && hold;
    endsequence

    supp_withhold_a : assert property (
        s_send_fault_held |=> !o_tx.valid)
        else $error("fault code sent during suppression");

    supp_expiry_a : assert property (
        state.phase == ST_SEND && state.fault && !hold |=> o_tx.valid
            && o_tx.value == $past(state.clamped))
        else $error("fault code not sent after expiry");

    inrange_send_a : assert property (
        state.phase == ST_SEND && !state.fault |=> o_tx.valid)
        else $error("in-range value not transferred");

    unipolar_clamp_a : assert property (
        i_cfg.unipolar_en && !i_cfg.mean_active && i_raw < 0
            && i_raw != AVP_CODE_UNDERFLOW |-> clamp_val == AVP_ZERO)
        else $error("negative value not clamped");

    wire_break_a : assert property (
        i_cfg.src_input_module && !i_cfg.src_software
            && i_raw == AVP_CODE_UNDERFLOW |-> clamp_val == AVP_CODE_UNDERFLOW)
        else $error("wire break code altered");

    mean_no_clamp_a : assert property (
        i_cfg.mean_active |-> clamp_val == i_raw)
        else $error("clamp active under mean generation");

    flag_stable_a : assert property (
        state.phase != ST_SEND |=> $stable(o_tx.range_violation_flag))
        else $error("flag changed outside transfer");

    cycle_period_a : assert property (
        cycle_tick |=> !cycle_tick [*2])
        else $error("cycle ticks too close");

    high_limit_a : assert property (
        state.phase == ST_SEND && i_cfg.status_proto && lim_allowed && !state.fault
            && i_cfg.lim_high != 0 && smoothed > i_cfg.lim_high
            |=> o_tx.range_violation_flag)
        else $error("high limit violation not flagged");

    // in-range transfer that updates the flag
    assign lim_step = state.phase == ST_SEND && !state.fault
                      && i_cfg.status_proto && lim_allowed;

    // under low limit sets flag
    low_limit_a : assert property (
        lim_step && i_cfg.lim_low != 0 && smoothed < i_cfg.lim_low
            |=> o_tx.range_violation_flag)
        else $error("low limit violation not flagged");

    // inside both limits clears flag
    flag_clear_a : assert property (
        lim_step && (i_cfg.lim_high == 0 || smoothed < i_cfg.lim_high)
            && (i_cfg.lim_low == 0 || smoothed > i_cfg.lim_low)
            |=> !o_tx.range_violation_flag)
        else $error("flag not cleared inside limits");

    // both limits zero keep flag low
    limits_off_a : assert property (
        lim_step && i_cfg.lim_high == 0 && i_cfg.lim_low == 0
            |=> !o_tx.range_violation_flag)
        else $error("flag raised with limits off");

    // input module points keep flag
    no_lim_module_a : assert property (
        state.phase == ST_SEND && i_cfg.src_input_module
            |=> $stable(o_tx.range_violation_flag))
        else $error("flag changed for input module point");

    // software input clamps all negatives
    software_clamp_a : assert property (
        i_cfg.unipolar_en && !i_cfg.mean_active && i_cfg.src_software && i_raw < 0
            |-> clamp_val == AVP_ZERO)
        else $error("software value not clamped");

    // gated-off suppression never holds
    supp_mean_off_a : assert property (
        !i_cfg.trig_cfg || i_cfg.mean_active
            |-> !hold)
        else $error("suppression active while gated off");

    // bypassed smoother passes sample
    smooth_bypass_a : assert property (
        state.phase == ST_EVAL && !state.fault && smooth_off
            |=> smoothed == $past(state.clamped))
        else $error("smoothing active while gated off");

    // strobe lasts one cycle
    valid_pulse_a : assert property (
        o_tx.valid |=> !o_tx.valid)
        else $error("transfer strobe longer than one cycle");

    // zero duration never withholds
    supp_zero_a : assert property (
        state.phase == ST_SEND && i_cfg.supp_cycles == 16'h0000
            |-> !hold)
        else $error("code withheld with zero duration");

endmodule : avp_preproc

`default_nettype wire

// ### rtl/avp_smooth.sv
/*
 * First order smoothing: y = (x + (k-1)*y_prev) / k with k a power of two.
 * Assumes one update strobe per in-range preprocessing cycle from the top module.
 */
`timescale 1ns/1ps
`default_nettype none

module avp_smooth (
    input  wire logic               i_clk_sys,
    input  wire logic               i_nrst,
    input  wire logic               i_step,
    input  wire logic               i_bypass,
    input  wire avp_pkg::avp_kfac_t i_kfac,
    input  wire logic signed [15:0] i_sample,
    output logic signed [15:0]      o_smoothed
);
    import avp_pkg::*;

    typedef struct packed {
        logic              primed;
        logic signed [15:0] y;
    } avp_sm_state_t;

    avp_sm_state_t state;
    avp_sm_state_t next_state;

    // shift for selected factor
    function automatic logic [2:0] avp_kshift(input avp_kfac_t k);
        unique case (k)
            AVP_K1:  avp_kshift = AVP_SHIFT_K1;
            AVP_K4:  avp_kshift = AVP_SHIFT_K4;
            AVP_K32: avp_kshift = AVP_SHIFT_K32;
            AVP_K64: avp_kshift = AVP_SHIFT_K64;
        endcase
    endfunction : avp_kshift

    // ========================================================================
    // recurrence
    // ========================================================================
    always_comb begin
        logic signed [23:0] acc;
        logic [2:0]         sh;
        acc = 24'sh000000;
        sh  = avp_kshift(i_kfac);
        next_state = state;
        if (i_step) begin
            if (i_bypass || !state.primed || sh == AVP_SHIFT_K1) begin
                next_state.y = i_sample;
            end else begin
                // x + k*y - y, then arithmetic divide by k
                acc = 24'(i_sample) + (24'(state.y) <<< sh) - 24'(state.y);
                next_state.y = 16'(acc >>> sh);
            end
            next_state.primed = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_smoothed = state.y;

    // k1 means pass-through
    k1_passes_a : assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_step && i_kfac == AVP_K1 |=> o_smoothed == $past(i_sample))
        else $error("k of one does not pass the sample");

endmodule : avp_smooth

`default_nettype wire

// ### rtl/avp_supp_timer.sv
/*
 * Fault suppression timer: counts preprocessing cycles while the value
 * sits on an overflow or underflow code.
 * Assumes the top module strobes i_step once per preprocessing cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module avp_supp_timer (
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    input  wire logic        i_step,
    input  wire logic        i_enable,
    input  wire logic        i_fault,
    input  wire logic [15:0] i_duration,
    output logic             o_hold
);
    import avp_pkg::*;

    typedef struct packed {
        logic [15:0] count;
    } avp_tm_state_t;

    avp_tm_state_t state;
    avp_tm_state_t next_state;

    // ========================================================================
    // counter: starts on fault entry, cleared on return into range
    // ========================================================================
    always_comb begin
        next_state = state;
        if (i_step) begin
            if (!i_enable || !i_fault) begin
                next_state.count = 16'h0000;
            end else if (state.count != 16'hFFFF) begin
                next_state.count = state.count + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // withhold while fewer than duration cycles have elapsed
    assign o_hold = i_enable && i_fault && (state.count < i_duration);

endmodule : avp_supp_timer

`default_nettype wire

// ### testbench/avp_image_model.sv
/*
 * Far-side model of one data point: the controller memory image word that
 * feeds the raw value, and a telemetry sink that counts transfers.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module avp_image_model (
    input  wire logic               i_clk_sys,
    input  wire logic               i_nrst,
    input  wire logic               i_wr,
    input  wire logic signed [15:0] i_wr_val,
    input  wire avp_pkg::avp_tx_t   i_tx,
    output logic signed [15:0]      o_raw,
    output logic [15:0]             o_rx_count
);
    import avp_pkg::*;

    logic signed [15:0] image = 16'sh0000;

    // ========================================================================
    // image word, written by the bench, survives reset like real memory
    // ========================================================================
    always @(posedge i_clk_sys) begin
        if (i_wr) begin
            image <= i_wr_val;
        end
    end
    assign o_raw = image;

    // telemetry sink counts every transfer pulse
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_rx_count <= 16'h0000;
        end else if (i_tx.valid) begin
            o_rx_count <= o_rx_count + 16'h0001;
        end
    end
endmodule : avp_image_model

`default_nettype wire

// ### testbench/avp_preproc_tb.sv
/*
 * Self-checking bench for the analog value preprocessor: clamp, fault
 * suppression, smoothing and limit flag, through image writes and transfers.
 * Assumes a short preprocessing cycle set by parameter.
 */
`timescale 1ns/1ps
`default_nettype none

module avp_preproc_tb;
    import avp_pkg::*;

    localparam int CYC = 8;

    logic               i_clk_sys;
    logic               i_nrst;
    logic               wr;
    logic signed [15:0] wr_val;
    logic signed [15:0] raw;
    logic               tick;
    logic [15:0]        rx_count;
    avp_cfg_t           cfg;
    avp_cfg_t           c;
    avp_tx_t            tx;
    int                 errors;
    int                 tests_run;
    int                 k;
    int                 kv;

    // ========================================================================
    // clock and instances
    // ========================================================================
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    avp_preproc #(.CYCLE_CLKS(CYC)) avp_preproc_inst (
        .i_clk_sys    (i_clk_sys),
        .i_nrst       (i_nrst),
        .i_cfg        (cfg),
        .i_raw        (raw),
        .o_tx         (tx),
        .o_cycle_tick (tick)
    );

    avp_image_model avp_image_model_inst (
        .i_clk_sys  (i_clk_sys),
        .i_nrst     (i_nrst),
        .i_wr       (wr),
        .i_wr_val   (wr_val),
        .i_tx       (tx),
        .o_raw      (raw),
        .o_rx_count (rx_count)
    );

    // ========================================================================
    // tasks
    // ========================================================================
    task automatic test_done;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // apply config with reset, then check cleared outputs
    task automatic do_reset(input avp_cfg_t nc);
        @(posedge i_clk_sys);
        cfg <= nc;
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        @(negedge i_clk_sys);
        chk(tx.value, 16'h0000);
        chk({14'h0000, tx.valid, tx.range_violation_flag}, 16'h0000);
    endtask : do_reset

    task automatic set_cfg(input avp_cfg_t nc);
        @(posedge i_clk_sys);
        cfg <= nc;
    endtask : set_cfg

    // write image, wait for capture, check the transfer three edges later
    task automatic xfer(input logic [15:0] v, input logic ev,
                        input logic [15:0] ex, input logic ef);
        int          n;
        logic [15:0] c0;
        @(posedge i_clk_sys);
        wr <= 1'b1;
        wr_val <= v;
        @(posedge i_clk_sys);
        wr <= 1'b0;
        n = 0;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (tick !== 1'b1 && n < 2 * CYC + 2);
        if (tick !== 1'b1) begin
            errors++;
            test_done();
        end
        c0 = rx_count;
        repeat (3) @(negedge i_clk_sys);
        chk({15'h0000, tx.valid}, {15'h0000, ev});
        if (ev) begin
            chk(tx.value, ex);
            chk({15'h0000, tx.range_violation_flag}, {15'h0000, ef});
        end
        @(negedge i_clk_sys);
        chk(rx_count - c0, {15'h0000, ev});
    endtask : xfer

    task automatic lim(input logic [15:0] v, input logic f);
        xfer(v, 1'b1, v, f);
    endtask : lim

    // ========================================================================
    // main sequence
    // ========================================================================
    initial begin
        errors = 0;
        tests_run = 0;
        i_nrst = 1'b0;
        wr = 1'b0;
        wr_val = 16'sh0000;
        cfg = '0;
        // clamp
        c = '0;
        c.unipolar_en = 1'b1;
        c.src_software = 1'b1;
        do_reset(c);
        xfer(16'hFFFB, 1'b1, 16'h0000, 1'b0);
        xfer(16'h8000, 1'b1, 16'h0000, 1'b0);
        c.src_software = 1'b0;
        c.src_input_module = 1'b1;
        set_cfg(c);
        xfer(16'h8000, 1'b1, 16'h8000, 1'b0);
        xfer(16'hFFFB, 1'b1, 16'h0000, 1'b0);
        c.mean_active = 1'b1;
        set_cfg(c);
        xfer(16'hFFFB, 1'b1, 16'hFFFB, 1'b0);
        $display("test clamp done");
        // fault suppression over three cycles
        c = '0;
        c.trig_cfg = 1'b1;
        c.supp_cycles = 16'h0003;
        c.status_proto = 1'b1;
        do_reset(c);
        xfer(16'h7FFF, 1'b0, 16'h0000, 1'b0);
        xfer(16'h7FFF, 1'b0, 16'h0000, 1'b0);
        xfer(16'h7FFF, 1'b1, 16'h7FFF, 1'b0);
        xfer(16'h8000, 1'b1, 16'h8000, 1'b0);
        xfer(16'h003C, 1'b1, 16'h003C, 1'b0);
        xfer(16'h8000, 1'b0, 16'h0000, 1'b0);
        xfer(16'h8000, 1'b0, 16'h0000, 1'b0);
        xfer(16'h8000, 1'b1, 16'h8000, 1'b0);
        c.mean_active = 1'b1;
        set_cfg(c);
        xfer(16'h7FFF, 1'b1, 16'h7FFF, 1'b0);
        $display("test suppression done");
        // smoothing for every factor
        for (k = 0; k < 4; k++) begin
            c = '0;
            c.trig_cfg = 1'b1;
            c.kfac = avp_kfac_t'(k);
            kv = (k == 0) ? 1 : (k == 1) ? 4 : (k == 2) ? 32 : 64;
            do_reset(c);
            xfer(16'h0000, 1'b1, 16'h0000, 1'b0);
            xfer(16'(100 * kv), 1'b1, 16'h0064, 1'b0);
            xfer(16'(100 * kv), 1'b1, 16'((100 * kv + (kv - 1) * 100) / kv), 1'b0);
        end
        c.mean_active = 1'b1;
        set_cfg(c);
        xfer(16'h0100, 1'b1, 16'h0100, 1'b0);
        $display("test smoothing done");
        // limit flag
        c = '0;
        c.trig_cfg = 1'b1;
        c.status_proto = 1'b1;
        c.lim_high = 16'sh03E8;
        c.lim_low = 16'shFC18;
        do_reset(c);
        lim(16'h03E9, 1'b1);
        lim(16'h03E8, 1'b1);
        lim(16'h03E7, 1'b0);
        lim(16'hFC17, 1'b1);
        lim(16'hFC18, 1'b1);
        lim(16'hFC19, 1'b0);
        c.lim_high = 16'sh0000;
        set_cfg(c);
        lim(16'h7530, 1'b0);
        lim(16'hF830, 1'b1);
        c.status_proto = 1'b0;
        set_cfg(c);
        lim(16'h0000, 1'b1);
        c.status_proto = 1'b1;
        c.src_input_module = 1'b1;
        set_cfg(c);
        lim(16'h0000, 1'b1);
        c.src_input_module = 1'b0;
        c.lim_high = 16'sh7EFF;
        c.lim_low = 16'sh0000;
        set_cfg(c);
        lim(16'h6C01, 1'b0);
        c.lim_high = 16'sh6C00;
        set_cfg(c);
        lim(16'h6C01, 1'b1);
        // smoothing ahead of the limit absorbs one spike
        c = '0;
        c.trig_cfg = 1'b1;
        c.status_proto = 1'b1;
        c.kfac = AVP_K4;
        c.lim_high = 16'sh03E8;
        do_reset(c);
        xfer(16'h0000, 1'b1, 16'h0000, 1'b0);
        xfer(16'h0FA0, 1'b1, 16'h03E8, 1'b0);
        xfer(16'h0FA0, 1'b1, 16'h06D6, 1'b1);
        $display("test limits done");
        test_done();
    end
endmodule : avp_preproc_tb

`default_nettype wire
